// [hdl/swl_dev.sv]
// gauge end of the single-wire link with host interrupt master
//
// Function
// RQ1 - all bytes and words go LSB first
// RQ2 - command: 7-bit code, direction in bit 7
// RQ3 - write takes 8/16 bits, read returns 8
// RQ4 - long low is break, resync to command
// RQ5 - host releases line for recovery after break
// RQ6 - device only pulls low, never drives high
// RQ7 - link both transmits and receives
// RQ8 - slave only until interrupt enable command
// RQ9 - no arbitration, both avoid collisions
// RQ10 - interrupt message is byte 0x80
// RQ11 - interrupt message has no data byte
// RQ12 - repeat once per second while condition holds
// RQ13 - try limit loaded from nonvolatile parameter
// RQ14 - low-charge flag raises interrupt condition
// RQ15 - charge-inhibit flag raises interrupt condition
// RQ16 - link inactive until explicitly enabled
// RQ17 - sleeping device may hold line up to 4ms
// RQ18 - both flags are status inputs from gauge
// RQ19 - bit cell: falling edge, low length gives value
// RQ20 - send interrupt only on idle line
`timescale 1ns/1ps
`default_nettype none
`include "swl_defines.svh"
module swl_dev
  import swl_pkg::*;
#(
  parameter swl_cnt_t BRK_CYC = `SWL_CNT_W'((`SWL_T_BREAK_NS + `SWL_CLK_NS - 1) / `SWL_CLK_NS),
  parameter swl_cnt_t CELL_CYC = `SWL_CNT_W'(`SWL_T_CELL_NS / `SWL_CLK_NS),
  parameter swl_cnt_t LOW1_CYC = `SWL_CNT_W'(`SWL_T_LOW1_NS / `SWL_CLK_NS),
  parameter swl_cnt_t LOW0_CYC = `SWL_CNT_W'(`SWL_T_LOW0_NS / `SWL_CLK_NS),
  parameter swl_cnt_t THR_CYC = `SWL_CNT_W'(`SWL_T_THR_NS / `SWL_CLK_NS),
  parameter swl_cnt_t TURN_CYC = `SWL_CNT_W'((`SWL_T_TURN_NS + `SWL_CLK_NS - 1) / `SWL_CLK_NS),
  parameter swl_cnt_t COMMIT_CYC = `SWL_CNT_W'((`SWL_T_COMMIT_NS + `SWL_CLK_NS - 1) / `SWL_CLK_NS),
  parameter swl_cnt_t GUARD_CYC = `SWL_CNT_W'((`SWL_T_GUARD_NS + `SWL_CLK_NS - 1) / `SWL_CLK_NS),
  parameter swl_cnt_t HOLD_CYC = `SWL_CNT_W'(`SWL_T_HOLD_NS / `SWL_CLK_NS),
  parameter swl_cnt_t SEC_CYC = `SWL_CNT_W'(`SWL_T_SEC_NS / `SWL_CLK_NS)
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  swl_if.dev lnk,
  input wire logic i_link_enable,
  input wire logic i_sleep_hold,
  input wire logic [7:0] i_rd_data,
  input wire logic i_low_charge_flag,
  input wire logic i_charge_inhibit_flag,
  input wire logic [7:0] i_retry_limit,
  output var logic o_wr_valid,
  output var logic o_wr_wide,
  output var logic [15:0] o_wr_data,
  output var logic o_rd_req,
  output var logic [6:0] o_reg_addr,
  output var logic o_irq_enabled,
  output var logic o_irq_sent
);

  // ----------------------------------------
  // line sampling
  // ----------------------------------------
  logic ln_s1_r;
  logic ln_s2_r;
  logic ln_d_r;
  swl_cnt_t lo_cnt_r;
  swl_cnt_t hi_cnt_r;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ln_s1_r <= 1'b1;
      ln_s2_r <= 1'b1;
      ln_d_r <= 1'b1;
    end else begin
      ln_s1_r <= lnk.line;
      ln_s2_r <= ln_s1_r;
      ln_d_r <= ln_s2_r;
    end
  end

  // RQ19 low and high length
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lo_cnt_r <= '0;
      hi_cnt_r <= '0;
    end else if (ln_s2_r) begin
      lo_cnt_r <= '0;
      hi_cnt_r <= swl_sat_inc(hi_cnt_r);
    end else begin
      hi_cnt_r <= '0;
      lo_cnt_r <= swl_sat_inc(lo_cnt_r);
    end
  end

  // ----------------------------------------
  // receive decode
  // ----------------------------------------
  swl_dev_st_t st_r;
  logic [15:0] sh_r;
  logic [4:0] bn_r;
  logic [7:0] cmd_r;
  logic [7:0] tx_sh_r;
  logic [2:0] tx_n_r;
  swl_cnt_t cc_r;
  logic irq_en_r;
  logic irq_pend_r;
  logic [7:0] tries_r;
  swl_cnt_t sec_cnt_r;

  logic fall;
  logic rise;
  logic rx_ok;
  logic brk;
  logic bit_ev;
  logic [15:0] sh_nxt;
  logic d_full;
  logic d_half;
  logic commit;
  logic [15:0] cm_data;
  logic is_ctl;
  logic irq_on;
  logic irq_off;
  logic hold_go;
  logic irq_start;
  logic tick;
  logic fire;

  assign fall = ln_d_r & ~ln_s2_r;
  assign rise = ~ln_d_r & ln_s2_r;
  // RQ16 gated by enable
  assign rx_ok = i_link_enable && st_r != SD_TX && st_r != SD_HOLD;
  // RQ4 break detect
  assign brk = rise && rx_ok && lo_cnt_r >= BRK_CYC;
  assign bit_ev = rise && rx_ok && !brk && (st_r == SD_CMD || st_r == SD_DATA);
  // RQ1 lsb first shift
  assign sh_nxt = {swl_rx_bit(lo_cnt_r, THR_CYC), sh_r[15:1]};
  // RQ3 8 or 16 data bits
  assign d_full = bit_ev && st_r == SD_DATA && bn_r == 5'd15;
  assign d_half = i_link_enable && st_r == SD_DATA && !bit_ev && bn_r == 5'd8 && hi_cnt_r >= COMMIT_CYC;
  assign commit = d_full || d_half;
  assign cm_data = d_full ? sh_nxt : {8'h00, sh_r[15:8]};
  // RQ8 enable by control command
  assign is_ctl = d_full && cmd_r[6:0] == `SWL_CTRL_CODE;
  assign irq_on = is_ctl && cm_data == `SWL_SUB_IRQ_EN;
  assign irq_off = is_ctl && cm_data == `SWL_SUB_IRQ_DIS;
  // RQ17 stall host while asleep
  assign hold_go = i_link_enable && fall && i_sleep_hold && !brk && (st_r == SD_IDLE || st_r == SD_CMD || st_r == SD_DATA);
  // RQ20 idle line guard
  assign irq_start = i_link_enable && irq_pend_r && ln_s2_r && hi_cnt_r >= GUARD_CYC && bn_r == 5'd0 &&
                     (st_r == SD_IDLE || st_r == SD_CMD);

  // ----------------------------------------
  // link sequencer
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= SD_IDLE;
      sh_r <= 16'h0000;
      bn_r <= 5'h00;
      cmd_r <= 8'h00;
      tx_sh_r <= 8'h00;
      tx_n_r <= 3'h0;
      cc_r <= '0;
      o_rd_req <= 1'b0;
      o_reg_addr <= 7'h00;
    end else begin
      o_rd_req <= 1'b0;
      if (!i_link_enable) begin
        st_r <= SD_IDLE;
        bn_r <= 5'h00;
      end else if (brk) begin
        // RQ4 resync on break
        st_r <= SD_CMD;
        bn_r <= 5'h00;
      end else if (hold_go) begin
        st_r <= SD_HOLD;
        cc_r <= '0;
      end else if (irq_start) begin
        // RQ10 fixed message
        tx_sh_r <= `SWL_IRQ_MSG;
        tx_n_r <= 3'h0;
        cc_r <= '0;
        st_r <= SD_TX;
      end else begin
        unique case (st_r)
          SD_IDLE: begin
            bn_r <= 5'h00;
          end
          SD_CMD: begin
            if (bit_ev) begin
              sh_r <= sh_nxt;
              bn_r <= bn_r + 5'd1;
              if (bn_r == 5'd7) begin
                // RQ2 code and direction
                cmd_r <= sh_nxt[15:8];
                o_reg_addr <= sh_nxt[14:8];
                bn_r <= 5'h00;
                if (sh_nxt[8+`SWL_RW_BIT]) begin
                  st_r <= SD_DATA;
                end else begin
                  st_r <= SD_TURN;
                  cc_r <= '0;
                  o_rd_req <= 1'b1;
                end
              end
            end
          end
          SD_DATA: begin
            if (bit_ev) begin
              sh_r <= sh_nxt;
              bn_r <= bn_r + 5'd1;
            end
            if (commit || (!bit_ev && hi_cnt_r >= COMMIT_CYC)) begin
              st_r <= SD_CMD;
              bn_r <= 5'h00;
            end
          end
          SD_TURN: begin
            cc_r <= cc_r + 1'b1;
            if (cc_r >= TURN_CYC) begin
              // RQ3 read returns 8 bits
              tx_sh_r <= i_rd_data;
              tx_n_r <= 3'h0;
              cc_r <= '0;
              st_r <= SD_TX;
            end
          end
          SD_TX: begin
            cc_r <= cc_r + 1'b1;
            if (cc_r == CELL_CYC - 1'b1) begin
              // RQ1 next bit up
              cc_r <= '0;
              tx_sh_r <= {1'b0, tx_sh_r[7:1]};
              tx_n_r <= tx_n_r + 3'd1;
              // RQ11 single byte only
              if (tx_n_r == 3'd7) begin
                st_r <= SD_CMD;
                bn_r <= 5'h00;
              end
            end
          end
          SD_HOLD: begin
            cc_r <= cc_r + 1'b1;
            // RQ17 bounded stall
            if (!i_sleep_hold || cc_r >= HOLD_CYC - 1'b1) begin
              st_r <= SD_IDLE;
            end
          end
          default: begin
            st_r <= SD_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // write port
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wr_valid <= 1'b0;
      o_wr_wide <= 1'b0;
      o_wr_data <= 16'h0000;
    end else begin
      o_wr_valid <= commit && !irq_on && !irq_off;
      if (commit) begin
        o_wr_wide <= d_full;
        o_wr_data <= cm_data;
      end
    end
  end

  // ----------------------------------------
  // host interrupt scheduler
  // ----------------------------------------
  // RQ12 one second tick
  assign tick = sec_cnt_r >= SEC_CYC - 1'b1;
  // RQ14 RQ15 RQ18 condition flags
  assign fire = tick && irq_en_r && (i_low_charge_flag || i_charge_inhibit_flag) && tries_r != 8'h00;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sec_cnt_r <= '0;
    end else begin
      sec_cnt_r <= tick ? '0 : sec_cnt_r + 1'b1;
    end
  end

  // RQ8 slave only from reset
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_en_r <= 1'b0;
      tries_r <= 8'h00;
    end else if (irq_on) begin
      // RQ13 load try limit
      irq_en_r <= 1'b1;
      tries_r <= i_retry_limit;
    end else if (irq_off || !i_link_enable) begin
      irq_en_r <= 1'b0;
    end else if (fire) begin
      tries_r <= tries_r - 8'd1;
    end
  end

  // RQ9 pending until line quiet
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_pend_r <= 1'b0;
      o_irq_sent <= 1'b0;
      o_irq_enabled <= 1'b0;
    end else begin
      o_irq_sent <= irq_start;
      o_irq_enabled <= irq_en_r;
      if (fire) begin
        irq_pend_r <= 1'b1;
      end else if (irq_start || !irq_en_r) begin
        irq_pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lnk.dev_oe <= 1'b0;
      lnk.dev_out <= 1'b0;
    end else begin
      // RQ6 only pull low
      lnk.dev_out <= 1'b0;
      // RQ7 RQ19 transmit cell
      if (st_r == SD_TX) begin
        lnk.dev_oe <= cc_r < (tx_sh_r[0] ? LOW1_CYC : LOW0_CYC);
      end else begin
        lnk.dev_oe <= st_r == SD_HOLD;
      end
    end
  end

endmodule
`default_nettype wire

// [include/swl_defines.svh]
// timing, framing and command constants of the single-wire link
`ifndef SWL_DEFINES_SVH
`define SWL_DEFINES_SVH
`define SWL_CNT_W 28
`define SWL_CLK_NS 4
`define SWL_T_BREAK_NS 190000
`define SWL_T_BRK_REC_NS 40000
`define SWL_T_CELL_NS 190000
`define SWL_T_LOW1_NS 40000
`define SWL_T_LOW0_NS 130000
`define SWL_T_THR_NS 85000
`define SWL_T_TURN_NS 50000
`define SWL_T_COMMIT_NS 300000
`define SWL_T_GUARD_NS 300000
`define SWL_T_HOLD_NS 4000000
`define SWL_T_SEC_NS 1000000000
`define SWL_T_RXTO_NS 1000000
`define SWL_RW_BIT 7
`define SWL_IRQ_MSG 8'h80
`define SWL_CTRL_CODE 7'h00
`define SWL_SUB_IRQ_EN 16'h0A51
`define SWL_SUB_IRQ_DIS 16'h0A50
`endif

// [include/swl_pkg.sv]
// shared types and helpers of the single-wire link
`include "swl_defines.svh"
package swl_pkg;
  typedef logic [`SWL_CNT_W-1:0] swl_cnt_t;
  typedef enum logic [2:0] {
    SD_IDLE = 3'b000,
    SD_CMD = 3'b001,
    SD_DATA = 3'b010,
    SD_TURN = 3'b011,
    SD_TX = 3'b100,
    SD_HOLD = 3'b101
  } swl_dev_st_t;
  typedef enum logic [2:0] {
    SH_IDLE = 3'b000,
    SH_BRK = 3'b001,
    SH_REC = 3'b010,
    SH_TX = 3'b011,
    SH_RX = 3'b100
  } swl_host_st_t;
  // saturating increment
  function automatic swl_cnt_t swl_sat_inc(input swl_cnt_t c);
    return (&c) ? c : c + 1'b1;
  endfunction
  // short low is a one, long low a zero
  function automatic logic swl_rx_bit(input swl_cnt_t lo, input swl_cnt_t thr);
    return lo < thr;
  endfunction
endpackage

// [include/swl_if.sv]
// shared open-drain line between gauge end and host end
`timescale 1ns/1ps
`default_nettype none
interface swl_if;
  logic dev_oe;
  logic dev_out;
  logic host_oe;
  logic host_out;
  wire logic line;
  // pull-up gives the high level
  assign line = ~((dev_oe & ~dev_out) | (host_oe & ~host_out));
  modport dev (output dev_oe, output dev_out, input line);
  modport host (output host_oe, output host_out, input line);
endinterface
`default_nettype wire

// [hdl/swl_host.sv]
// host end of the single-wire link
`timescale 1ns/1ps
`default_nettype none
`include "swl_defines.svh"
module swl_host
  import swl_pkg::*;
#(
  parameter swl_cnt_t BRK_CYC = `SWL_CNT_W'((`SWL_T_BREAK_NS + `SWL_CLK_NS - 1) / `SWL_CLK_NS),
  parameter swl_cnt_t REC_CYC = `SWL_CNT_W'((`SWL_T_BRK_REC_NS + `SWL_CLK_NS - 1) / `SWL_CLK_NS),
  parameter swl_cnt_t CELL_CYC = `SWL_CNT_W'(`SWL_T_CELL_NS / `SWL_CLK_NS),
  parameter swl_cnt_t LOW1_CYC = `SWL_CNT_W'(`SWL_T_LOW1_NS / `SWL_CLK_NS),
  parameter swl_cnt_t LOW0_CYC = `SWL_CNT_W'(`SWL_T_LOW0_NS / `SWL_CLK_NS),
  parameter swl_cnt_t THR_CYC = `SWL_CNT_W'(`SWL_T_THR_NS / `SWL_CLK_NS),
  parameter swl_cnt_t GUARD_CYC = `SWL_CNT_W'((`SWL_T_GUARD_NS + `SWL_CLK_NS - 1) / `SWL_CLK_NS),
  parameter swl_cnt_t RXTO_CYC = `SWL_CNT_W'(`SWL_T_RXTO_NS / `SWL_CLK_NS)
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  swl_if.host lnk,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic i_cmd_wide,
  input wire logic [6:0] i_cmd_code,
  input wire logic [15:0] i_cmd_wdata,
  output var logic o_ready,
  output var logic o_rd_valid,
  output var logic [7:0] o_rd_data,
  output var logic o_rd_timeout,
  output var logic o_irq_seen
);

  // ----------------------------------------
  // line sampling
  // ----------------------------------------
  logic ln_s1_r;
  logic ln_s2_r;
  logic ln_d_r;
  swl_cnt_t lo_cnt_r;
  swl_cnt_t hi_cnt_r;
  swl_host_st_t st_r;
  logic [23:0] tx_sh_r;
  logic [4:0] tx_n_r;
  logic [4:0] tx_len_r;
  logic rd_r;
  logic [7:0] rsh_r;
  logic [3:0] rbn_r;
  swl_cnt_t cc_r;
  logic rise;
  logic bit_ev;
  logic [7:0] rsh_nxt;
  logic take;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ln_s1_r <= 1'b1;
      ln_s2_r <= 1'b1;
      ln_d_r <= 1'b1;
    end else begin
      ln_s1_r <= lnk.line;
      ln_s2_r <= ln_s1_r;
      ln_d_r <= ln_s2_r;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lo_cnt_r <= '0;
      hi_cnt_r <= '0;
    end else if (ln_s2_r) begin
      lo_cnt_r <= '0;
      hi_cnt_r <= swl_sat_inc(hi_cnt_r);
    end else begin
      hi_cnt_r <= '0;
      lo_cnt_r <= swl_sat_inc(lo_cnt_r);
    end
  end

  assign rise = ~ln_d_r & ln_s2_r;
  // RQ19 decode a received cell
  assign bit_ev = rise && lo_cnt_r < BRK_CYC && (st_r == SH_IDLE || st_r == SH_RX);
  // RQ1 lsb first
  assign rsh_nxt = {swl_rx_bit(lo_cnt_r, THR_CYC), rsh_r[7:1]};
  assign take = i_cmd_valid && o_ready;

  // ----------------------------------------
  // transfer sequencer
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= SH_IDLE;
      tx_sh_r <= 24'h000000;
      tx_n_r <= 5'h00;
      tx_len_r <= 5'h00;
      rd_r <= 1'b0;
      rsh_r <= 8'h00;
      rbn_r <= 4'h0;
      cc_r <= '0;
      o_ready <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data <= 8'h00;
      o_rd_timeout <= 1'b0;
      o_irq_seen <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      o_rd_timeout <= 1'b0;
      o_irq_seen <= 1'b0;
      // RQ9 start only on a quiet line
      o_ready <= st_r == SH_IDLE && !take && ln_s2_r && hi_cnt_r >= GUARD_CYC && rbn_r == 4'h0;
      if (bit_ev) begin
        rsh_r <= rsh_nxt;
        rbn_r <= rbn_r + 4'd1;
      end
      unique case (st_r)
        SH_IDLE: begin
          if (take) begin
            // RQ2 RQ3 command then data
            tx_sh_r <= {i_cmd_wdata, i_cmd_write, i_cmd_code};
            tx_len_r <= !i_cmd_write ? 5'd8 : (i_cmd_wide ? 5'd24 : 5'd16);
            rd_r <= !i_cmd_write;
            tx_n_r <= 5'h00;
            cc_r <= '0;
            st_r <= SH_BRK;
          end else if (bit_ev && rbn_r == 4'd7) begin
            rbn_r <= 4'h0;
            o_irq_seen <= rsh_nxt == `SWL_IRQ_MSG;
          end else if (rbn_r != 4'h0 && hi_cnt_r >= GUARD_CYC) begin
            rbn_r <= 4'h0;
          end
        end
        SH_BRK: begin
          cc_r <= cc_r + 1'b1;
          if (cc_r >= BRK_CYC + 1'b1) begin
            cc_r <= '0;
            st_r <= SH_REC;
          end
        end
        SH_REC: begin
          cc_r <= cc_r + 1'b1;
          // RQ5 recovery high time
          if (cc_r >= REC_CYC - 1'b1) begin
            cc_r <= '0;
            st_r <= SH_TX;
          end
        end
        SH_TX: begin
          cc_r <= cc_r + 1'b1;
          if (cc_r == CELL_CYC - 1'b1) begin
            cc_r <= '0;
            tx_sh_r <= {1'b0, tx_sh_r[23:1]};
            tx_n_r <= tx_n_r + 5'd1;
            if (tx_n_r == tx_len_r - 5'd1) begin
              rbn_r <= 4'h0;
              st_r <= rd_r ? SH_RX : SH_IDLE;
            end
          end
        end
        SH_RX: begin
          cc_r <= bit_ev ? '0 : cc_r + 1'b1;
          if (bit_ev && rbn_r == 4'd7) begin
            rbn_r <= 4'h0;
            o_rd_valid <= 1'b1;
            o_rd_data <= rsh_nxt;
            st_r <= SH_IDLE;
          end else if (cc_r >= RXTO_CYC) begin
            rbn_r <= 4'h0;
            o_rd_timeout <= 1'b1;
            st_r <= SH_IDLE;
          end
        end
        default: begin
          st_r <= SH_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lnk.host_oe <= 1'b0;
      lnk.host_out <= 1'b0;
    end else begin
      lnk.host_out <= 1'b0;
      // RQ19 break and bit cells
      if (st_r == SH_BRK) begin
        lnk.host_oe <= 1'b1;
      end else if (st_r == SH_TX) begin
        lnk.host_oe <= cc_r < (tx_sh_r[0] ? LOW1_CYC : LOW0_CYC);
      end else begin
        lnk.host_oe <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [testbench/swl_line_checker.sv]
// concurrent checks on the shared single-wire line
`timescale 1ns/1ps
`default_nettype none
module swl_line_checker #(
  parameter int LOW1 = 10,
  parameter int LOW0 = 35,
  parameter int BRK = 40,
  parameter int REC = 10,
  parameter int CELL = 60,
  parameter int HOLD = 500
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic dev_oe,
  input wire logic dev_out,
  input wire logic host_oe,
  input wire logic host_out,
  input wire logic line
);
  localparam int REC_TAIL = REC - 7;
  int dhi_r;
  int hhi_r;
  int dgap_r;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------
  // low and gap length counters
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dhi_r <= 0;
      hhi_r <= 0;
      dgap_r <= 0;
    end else begin
      dhi_r <= dev_oe ? dhi_r + 1 : 0;
      hhi_r <= host_oe ? hhi_r + 1 : 0;
      dgap_r <= dev_oe ? 0 : ((dgap_r < 1000) ? dgap_r + 1 : dgap_r);
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_brk_end;
    $fell(host_oe) && (hhi_r >= BRK);
  endsequence
  sequence s_rec;
    (!host_oe && line) [*8] ##[REC_TAIL:REC_TAIL] host_oe;
  endsequence
  property p_dev_low_only;
    dev_oe |-> !dev_out && !line;
  endproperty
  property p_host_low_only;
    host_oe |-> !host_out && !line;
  endproperty
  property p_dev_cell_low;
    $fell(dev_oe) |-> (dhi_r == LOW1) || (dhi_r == LOW0);
  endproperty
  property p_host_cell_low;
    $fell(host_oe) |-> (hhi_r == LOW1) || (hhi_r == LOW0) || (hhi_r == BRK + 2);
  endproperty
  property p_brk_rec;
    s_brk_end |-> s_rec;
  endproperty
  property p_dev_idle_start;
    $rose(dev_oe) |-> !host_oe && $past(line);
  endproperty
  property p_host_no_clash;
    $rose(host_oe) |-> !dev_oe;
  endproperty
  property p_dev_return_one;
    $rose(dev_oe) |-> dgap_r >= CELL - LOW0;
  endproperty
  property p_dev_hold_max;
    dev_oe |-> dhi_r < HOLD;
  endproperty
  a_dev_low_only: assert property (p_dev_low_only)
    else $error("gauge end drives line high");
  a_host_low_only: assert property (p_host_low_only)
    else $error("host end drives line high");
  a_dev_cell_low: assert property (p_dev_cell_low)
    else $error("gauge cell low time wrong");
  a_host_cell_low: assert property (p_host_cell_low)
    else $error("host cell low time wrong");
  a_brk_rec: assert property (p_brk_rec)
    else $error("break recovery time wrong");
  a_dev_idle_start: assert property (p_dev_idle_start)
    else $error("gauge started on busy line");
  a_host_no_clash: assert property (p_host_no_clash)
    else $error("host started while gauge pulls");
  a_dev_return_one: assert property (p_dev_return_one)
    else $error("gauge cell high time too short");
  a_dev_hold_max: assert property (p_dev_hold_max)
    else $error("gauge holds line too long");
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench joining gauge end and host end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int TMO = 60000;
  // shortened link timings; T_REC host only, T_TURN and T_HOLD gauge only; checker defaults match them
  localparam swl_pkg::swl_cnt_t T_BRK = 28'h28;
  localparam swl_pkg::swl_cnt_t T_REC = 28'h0A;
  localparam swl_pkg::swl_cnt_t T_CELL = 28'h3C;
  localparam swl_pkg::swl_cnt_t T_LOW1 = 28'h0A;
  localparam swl_pkg::swl_cnt_t T_LOW0 = 28'h23;
  localparam swl_pkg::swl_cnt_t T_THR = 28'h16;
  localparam swl_pkg::swl_cnt_t T_TURN = 28'h14;
  localparam swl_pkg::swl_cnt_t T_QUIET = 28'h96;
  localparam swl_pkg::swl_cnt_t T_HOLD = 28'h1F4;
  localparam swl_pkg::swl_cnt_t T_SEC = 28'h7D0;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_link_enable = 1'b0;
  logic i_sleep_hold = 1'b0;
  logic [7:0] i_rd_data = 8'h5C;
  logic i_low_charge_flag = 1'b0;
  logic i_charge_inhibit_flag = 1'b0;
  logic [7:0] i_retry_limit = 8'h02;
  logic i_cmd_valid = 1'b0;
  logic i_cmd_write = 1'b0;
  logic i_cmd_wide = 1'b0;
  logic [6:0] i_cmd_code = 7'h00;
  logic [15:0] i_cmd_wdata = 16'h0000;
  logic o_wr_valid, o_wr_wide, o_rd_req, o_irq_enabled, o_irq_sent;
  logic [15:0] o_wr_data;
  logic [6:0] o_reg_addr;
  logic o_ready, o_rd_valid, o_rd_timeout, o_irq_seen;
  logic [7:0] o_rd_data;
  logic [15:0] mon = 16'h0000;
  logic [16:0] wr_cap = 17'h00000;
  int lo, mon_n, sent_at, n_wr, n_rdq, n_rdv, n_seen, n_sent, n_to, cyc, err_count, n_tests;

  always #2 i_core_clk = ~i_core_clk;

  swl_if lnk_if();
  swl_dev #(.BRK_CYC(T_BRK), .CELL_CYC(T_CELL), .LOW1_CYC(T_LOW1), .LOW0_CYC(T_LOW0), .THR_CYC(T_THR),
    .TURN_CYC(T_TURN), .COMMIT_CYC(T_QUIET), .GUARD_CYC(T_QUIET), .HOLD_CYC(T_HOLD),
    .SEC_CYC(T_SEC)) swl_dev_i (.i_core_clk, .i_rst_n,
    .lnk(lnk_if.dev), .i_link_enable, .i_sleep_hold, .i_rd_data, .i_low_charge_flag, .i_charge_inhibit_flag,
    .i_retry_limit, .o_wr_valid, .o_wr_wide, .o_wr_data, .o_rd_req, .o_reg_addr, .o_irq_enabled, .o_irq_sent);
  swl_host #(.BRK_CYC(T_BRK), .REC_CYC(T_REC), .CELL_CYC(T_CELL), .LOW1_CYC(T_LOW1), .LOW0_CYC(T_LOW0),
    .THR_CYC(T_THR), .GUARD_CYC(T_QUIET), .RXTO_CYC(T_SEC)) swl_host_i (.i_core_clk, .i_rst_n,
    .lnk(lnk_if.host), .i_cmd_valid,
    .i_cmd_write, .i_cmd_wide, .i_cmd_code, .i_cmd_wdata, .o_ready, .o_rd_valid, .o_rd_data, .o_rd_timeout,
    .o_irq_seen);
  swl_line_checker swl_line_checker_i (
    .i_core_clk, .i_rst_n, .dev_oe(lnk_if.dev_oe), .dev_out(lnk_if.dev_out), .host_oe(lnk_if.host_oe),
    .host_out(lnk_if.host_out), .line(lnk_if.line));

  // ----------------------------------------
  // event counters and line bit monitor
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (o_wr_valid === 1'b1) begin
      n_wr <= n_wr + 1;
      wr_cap <= {o_wr_wide, o_wr_data};
    end
    if (o_rd_req === 1'b1) n_rdq <= n_rdq + 1;
    if (o_rd_valid === 1'b1) n_rdv <= n_rdv + 1;
    if (o_irq_seen === 1'b1) n_seen <= n_seen + 1;
    if (o_rd_timeout === 1'b1) n_to <= n_to + 1;
    if (o_irq_sent === 1'b1) begin
      n_sent <= n_sent + 1;
      sent_at <= mon_n;
    end
    if (lnk_if.line === 1'b0) begin
      lo <= lo + 1;
    end else begin
      if (lo > 0 && lo < 40) begin
        mon <= {(lo < 22), mon[15:1]};
        mon_n <= mon_n + 1;
      end
      lo <= 0;
    end
    if (cyc == TMO) begin
      err_count++;
      end_sim();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic xfer(input logic wr, input logic wide, input logic [6:0] code, input logic [15:0] data);
    int k;
    k = 0;
    while (o_ready !== 1'b1 && k < 5000) begin
      idle(1);
      k++;
    end
    i_cmd_valid = 1'b1;
    i_cmd_write = wr;
    i_cmd_wide = wide;
    i_cmd_code = code;
    i_cmd_wdata = data;
    idle(1);
    i_cmd_valid = 1'b0;
    idle(2);
    k = 0;
    while (o_ready !== 1'b1 && k < 5000) begin
      idle(1);
      k++;
    end
    idle(20);
  endtask

  task automatic wait_seen(input int n);
    int k;
    k = 0;
    while (o_irq_seen !== 1'b1 && k < n) begin
      idle(1);
      k++;
    end
    idle(2);
  endtask

  task end_sim;
    if (err_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    idle(4);
    i_rst_n = 1'b1;
    idle(10);
    chk(16'(lnk_if.line), 16'h0001);
    xfer(1'b1, 1'b0, 7'h15, 16'h00A5);
    chk(16'(n_wr), 16'h0000);
    i_link_enable = 1'b1;
    xfer(1'b1, 1'b0, 7'h15, 16'h00A5);
    chk(wr_cap[15:0], 16'h00A5);
    chk(16'(wr_cap[16]), 16'h0000);
    chk(16'(o_reg_addr), 16'h0015);
    chk(mon, 16'hA595);
    xfer(1'b1, 1'b1, 7'h2A, 16'h1234);
    chk(16'(n_wr), 16'h0002);
    chk(wr_cap[15:0], 16'h1234);
    chk(16'(wr_cap[16]), 16'h0001);
    chk(mon, 16'h1234);
    xfer(1'b0, 1'b0, 7'h33, 16'h0000);
    chk(16'(n_rdq), 16'h0001);
    chk(16'(o_reg_addr), 16'h0033);
    chk(16'(o_rd_data), 16'h005C);
    chk(16'(n_rdv), 16'h0001);
    chk(mon, 16'h5C33);
    chk(16'(n_to), 16'h0000);
    chk(16'(mon_n), 16'h0048);
    i_low_charge_flag = 1'b1;
    idle(2500);
    chk(16'(n_sent), 16'h0000);
    chk(16'(o_irq_enabled), 16'h0000);
    xfer(1'b1, 1'b1, 7'h00, 16'h0A51);
    chk(16'(n_wr), 16'h0002);
    chk(16'(o_irq_enabled), 16'h0001);
    idle(7000);
    chk(16'(n_seen), 16'h0002);
    chk(16'(n_sent), 16'h0002);
    chk(16'(mon[15:8]), 16'h0080);
    chk(16'(mon_n - sent_at), 16'h0008);
    i_low_charge_flag = 1'b0;
    i_retry_limit = 8'h01;
    xfer(1'b1, 1'b1, 7'h00, 16'h0A51);
    i_charge_inhibit_flag = 1'b1;
    wait_seen(3000);
    i_charge_inhibit_flag = 1'b0;
    chk(16'(n_seen), 16'h0003);
    xfer(1'b1, 1'b1, 7'h00, 16'h0A50);
    chk(16'(o_irq_enabled), 16'h0000);
    i_charge_inhibit_flag = 1'b1;
    i_retry_limit = 8'h05;
    idle(4500);
    chk(16'(n_sent), 16'h0003);
    chk(16'(n_seen), 16'h0003);
    end_sim();
  end
endmodule
`default_nettype wire
